/* hdl/spfm_pkg.sv */
`default_nettype none
package spfm_pkg;
    // ******************************
    // register byte addresses
    // ******************************
    localparam logic [7:0] ADDR_SER_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_SER_BUF      = 8'h04;
    localparam logic [7:0] ADDR_PWR_CTRL     = 8'h08;
    localparam logic [7:0] ADDR_T2_CTRL      = 8'h0C;
    localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'h10;
    localparam logic [7:0] ADDR_T2_RELOAD_HI = 8'h14;
    localparam logic [7:0] ADDR_T2_COUNT_LO  = 8'h18;
    localparam logic [7:0] ADDR_T2_COUNT_HI  = 8'h1C;
    localparam logic [7:0] ADDR_T1_RELOAD    = 8'h20;
    // ******************************
    // field positions
    // ******************************
    localparam int SC_SM2  = 5;
    localparam int SC_REN  = 4;
    localparam int SC_TB8  = 3;
    localparam int SC_RB8  = 2;
    localparam int SC_TI   = 1;
    localparam int SC_RI   = 0;
    localparam int PW_DOUBLE_RATE_BIT = 7;
    localparam int T2_OVF  = 7;
    localparam int T2_EXT  = 6;
    localparam int T2_RXB  = 5;
    localparam int T2_TXB  = 4;
    localparam int T2_EXEN = 3;
    localparam int T2_RUN  = 2;
    localparam int T2_CT   = 1;
    localparam int T2_CPRL = 0;
    // ******************************
    // modes, timing, frame sizes
    // ******************************
    localparam logic [1:0] MODE_SHIFT  = 2'b00;
    localparam logic [1:0] MODE_UART8  = 2'b01;
    localparam logic [1:0] MODE_UART9F = 2'b10;
    localparam logic [3:0] PH_LAST     = 4'd11;  // 12 oscillator periods per machine cycle
    localparam logic [3:0] PH_SCLK_LO0 = 4'd4;   // S3P1
    localparam logic [3:0] PH_SCLK_LO1 = 4'd9;   // S5P2
    localparam logic [3:0] PH_SAMPLE   = 4'd9;   // S5P2
    localparam logic [3:0] SMP_A       = 4'd7;
    localparam logic [3:0] SMP_B       = 4'd8;
    localparam logic [3:0] SMP_C       = 4'd9;
    localparam logic [3:0] DIV_LAST    = 4'd15;
    localparam logic [3:0] FRAME8_BITS = 4'd10;
    localparam logic [3:0] FRAME9_BITS = 4'd11;
    localparam logic [3:0] SHIFT_BITS  = 4'd8;
    localparam logic [1:0] PRE_LAST    = 2'd3;
    typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100} spfm_tx_t;
    typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_ASYNC = 3'b010, RX_SHIFT = 3'b100} spfm_rx_t;
    typedef struct packed {
        logic [1:0]  mode;
        logic        sm2;
        logic        ren;
        logic        tb8;
        logic        rb8;
        logic        ti;
        logic        ri;
        logic        double_rate_bit;
        logic [7:0]  rbuf;
        logic        t2ovf;
        logic        t2ext;
        logic        rxb2;
        logic        txb2;
        logic        t2exen;
        logic        t2run;
        logic        t2ct;
        logic        t2cprl;
        logic [15:0] t2cnt;
        logic [15:0] t2rel;
        logic [7:0]  t1cnt;
        logic [7:0]  t1rel;
        logic        t1half;
        logic [3:0]  ph;
        logic [1:0]  pre;
        logic        rxd_s1;
        logic        rxd_s2;
        logic        rxd_d;
        logic        t2x_s1;
        logic        t2x_s2;
        logic        t2x_d;
        spfm_tx_t    tx_st;
        logic [10:0] tx_sh;
        logic [3:0]  tx_cnt;
        logic [3:0]  tx_div;
        logic        txd;
        logic        sclk;
        logic        txp;
        logic        oe_n;
        spfm_rx_t    rx_st;
        logic [8:0]  rx_dat;
        logic [3:0]  rx_cnt;
        logic [3:0]  rx_div;
        logic        s7;
        logic        s8;
        logic [31:0] prd;
    } spfm_state_t;
    localparam spfm_state_t ST_RST = '{tx_st: TX_IDLE, rx_st: RX_IDLE, txd: 1'b1, sclk: 1'b1,
                                       txp: 1'b1, oe_n: 1'b1, rxd_s1: 1'b1, rxd_s2: 1'b1,
                                       rxd_d: 1'b1, t2x_s1: 1'b1, t2x_s2: 1'b1, t2x_d: 1'b1,
                                       default: '0};
endpackage : spfm_pkg
`default_nettype wire

/* hdl/spfm_top.sv */
// What this block does
// - transmitter and receiver run independently and at the same time
// - one buffer address: writes load transmit, reads return separate receive buffer
// - shift mode moves 8 bits LSB first on rx pin, clock on tx pin
// - 8-bit uart frame: start, 8 data LSB first, stop into rx ninth flag
// - 9-bit uart frames: start, 8 data, tx ninth bit, stop
// - 9-bit reception stores received ninth bit, ignores stop bit value
// - mode bits select shift, 8-bit variable, 9-bit fixed, 9-bit variable
// - fixed 9-bit mode runs at osc/64, or osc/32 with double rate
// - first timer overflow divided by 32, or 16 with double rate
// - second timer baud: osc/32 over 16-bit reload count
// - second timer in baud mode never sets its overflow flag
// - baud mode external edge sets external flag, no reload
// - baud mode timer increments every state time when running with t2ct clear
// - shift reception needs rx flag clear and enable; uart needs start bit
// - 9-bit modes with filter: ninth bit zero raises no rx flag
// - 8-bit mode with filter: rx flag only on valid stop bit
// - 8-bit mode without filter: rx ninth flag holds stop bit
// - tx flag set after eighth shift bit, or at stop bit start
// - rx flag set after eighth shift bit, or mid stop bit
// - shift-mode buffer write loads a one above the data byte
// - shift-mode send starts one full machine cycle after the first machine-cycle end following the write
// - uart receiver samples at 7, 8, 9 of 16 and takes majority
// - a start bit that reads as one resets the receiver
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module spfm_top
    import spfm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txd_out,
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe_n,
    input  wire logic        timer_two_external_input
);
    import spfm_pkg::*;

    spfm_state_t r;
    spfm_state_t n;
    logic        mc_tick;
    logic        st_tick;
    logic        baud2;
    logic        t2_inc;
    logic        t2_ovf;
    logic        t1_ovf;
    logic        t1_x16;
    logic        m2_x16;
    logic        tx_x16;
    logic        rx_x16;
    logic        t2_fall;
    logic        rx_fall;
    logic        maj;
    logic        shift_md;
    logic [3:0]  nbits;
    logic        wr;
    logic        wr_ctl;
    logic        wr_buf;
    logic        wr_t2c;
    logic        hit;

    // ******************************
    // rate enables
    // ******************************
    // oscillator equals pclk; machine cycle is 12 phases, a state is 2
    assign mc_tick  = r.ph == PH_LAST;
    assign st_tick  = r.ph[0];
    assign baud2    = r.rxb2 | r.txb2;
    assign t2_inc   = r.t2run & ~r.t2ct & (baud2 ? st_tick : mc_tick);
    assign t2_ovf   = t2_inc & (r.t2cnt == 16'hFFFF);
    assign t1_ovf   = mc_tick & (r.t1cnt == 8'hFF);
    assign t1_x16   = t1_ovf & (r.double_rate_bit | r.t1half);
    assign m2_x16   = r.double_rate_bit ? r.pre[0] : (r.pre == PRE_LAST);
    // second timer overflow already at 16x of osc/32 over the reload count
    assign tx_x16   = (r.mode == MODE_UART9F) ? m2_x16 : (r.txb2 ? t2_ovf : t1_x16);
    assign rx_x16   = (r.mode == MODE_UART9F) ? m2_x16 : (r.rxb2 ? t2_ovf : t1_x16);
    assign t2_fall  = r.t2x_d & ~r.t2x_s2;
    assign rx_fall  = r.rxd_d & ~r.rxd_s2;
    assign maj      = (r.s7 & r.s8) | (r.s7 & r.rxd_s2) | (r.s8 & r.rxd_s2);
    assign shift_md = r.mode == MODE_SHIFT;
    assign nbits    = (r.mode == MODE_UART8) ? FRAME8_BITS : FRAME9_BITS;

    // ******************************
    // apb decode
    // ******************************
    assign wr     = psel & penable & pwrite;
    assign wr_ctl = wr & (paddr == ADDR_SER_CTRL);
    assign wr_buf = wr & (paddr == ADDR_SER_BUF);
    assign wr_t2c = wr & (paddr == ADDR_T2_CTRL);
    assign hit    = (paddr[1:0] == 2'b00) & (paddr <= ADDR_T1_RELOAD);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = r.prd;
    assign txd_out = r.txp;
    assign rxd_out = r.tx_sh[0];
    assign rxd_oe_n = r.oe_n;

    // next-state logic for the whole block
    always_comb begin
        logic set_ti;
        logic set_ri;
        logic set_ovf;
        logic set_ext;
        logic ninth;
        set_ti  = 1'b0;
        set_ri  = 1'b0;
        set_ovf = 1'b0;
        set_ext = 1'b0;
        ninth   = 1'b0;
        n       = r;
        n.ph    = mc_tick ? 4'd0 : r.ph + 4'd1;
        n.pre   = r.pre + 2'd1;
        // pins from outside pass two flops before use
        n.rxd_s1 = rxd_in;
        n.rxd_s2 = r.rxd_s1;
        n.rxd_d  = r.rxd_s2;
        n.t2x_s1 = timer_two_external_input;
        n.t2x_s2 = r.t2x_s1;
        n.t2x_d  = r.t2x_s2;

        // ******************************
        // timers
        // ******************************
        // first timer: 8-bit auto-reload on machine cycles
        if (mc_tick) begin
            n.t1cnt = t1_ovf ? r.t1rel : r.t1cnt + 8'd1;
        end
        if (t1_ovf) begin
            n.t1half = ~r.t1half;
        end
        if (t2_inc) begin
            n.t2cnt = t2_ovf ? r.t2rel : r.t2cnt + 16'd1;
        end
        if (t2_ovf && !baud2) begin
            set_ovf = 1'b1;
        end
        // in baud mode the edge only flags; no reload or capture
        if (t2_fall && r.t2exen) begin
            set_ext = 1'b1;
            if (!baud2) begin
                if (r.t2cprl) begin
                    n.t2rel = r.t2cnt;
                end else begin
                    n.t2cnt = r.t2rel;
                end
            end
        end

        // ******************************
        // transmitter
        // ******************************
        if (tx_x16) begin
            n.tx_div = r.tx_div + 4'd1;
        end
        case (r.tx_st)
            TX_IDLE: begin
                n.tx_cnt = 4'd0;
            end
            TX_WAIT: begin
                if (shift_md) begin
                    // first tick is the load slot, send a full cycle later
                    if (mc_tick) begin
                        if (r.tx_cnt == 4'd0) begin
                            n.tx_cnt = 4'd1;
                        end else begin
                            n.tx_st  = TX_SEND;
                            n.tx_cnt = 4'd0;
                        end
                    end
                end else if (tx_x16 && r.tx_div == DIV_LAST) begin
                    // bit times follow the divider, not the write
                    n.tx_st  = TX_SEND;
                    n.tx_cnt = 4'd0;
                    n.txd    = r.tx_sh[0];
                end
            end
            TX_SEND: begin
                if (shift_md) begin
                    if (mc_tick) begin
                        n.tx_sh  = {1'b0, r.tx_sh[10:1]};
                        n.tx_cnt = r.tx_cnt + 4'd1;
                        if (r.tx_cnt == SHIFT_BITS - 4'd1) begin
                            set_ti  = 1'b1;
                            n.tx_st = TX_IDLE;
                        end
                    end
                end else if (tx_x16 && r.tx_div == DIV_LAST) begin
                    n.tx_sh  = {1'b1, r.tx_sh[10:1]};
                    n.tx_cnt = r.tx_cnt + 4'd1;
                    n.txd    = r.tx_sh[1];
                    if (r.tx_cnt + 4'd1 == nbits - 4'd1) begin
                        set_ti = 1'b1;
                    end
                    if (r.tx_cnt + 4'd1 == nbits) begin
                        n.tx_st = TX_IDLE;
                        n.txd   = 1'b1;
                    end
                end
            end
            default: begin
                n.tx_st = TX_IDLE;
            end
        endcase

        // ******************************
        // receiver
        // ******************************
        case (r.rx_st)
            RX_IDLE: begin
                n.rx_cnt = 4'd0;
                if (shift_md) begin
                    if (r.ren && !r.ri && mc_tick) begin
                        n.rx_st = RX_SHIFT;
                    end
                end else if (r.ren && rx_fall) begin
                    n.rx_st  = RX_ASYNC;
                    n.rx_div = 4'd0;
                end
            end
            RX_SHIFT: begin
                if (r.ph == PH_SAMPLE) begin
                    n.s7 = r.rxd_s2;
                end
                if (mc_tick) begin
                    n.rx_dat = {r.s7, r.rx_dat[8:1]};
                    n.rx_cnt = r.rx_cnt + 4'd1;
                    if (r.rx_cnt == SHIFT_BITS - 4'd1) begin
                        n.rbuf  = {r.s7, r.rx_dat[8:2]};
                        set_ri  = 1'b1;
                        n.rx_st = RX_IDLE;
                    end
                end
            end
            RX_ASYNC: begin
                if (rx_x16) begin
                    n.rx_div = r.rx_div + 4'd1;
                    if (r.rx_div == SMP_A) begin
                        n.s7 = r.rxd_s2;
                    end
                    if (r.rx_div == SMP_B) begin
                        n.s8 = r.rxd_s2;
                    end
                    if (r.rx_div == SMP_C) begin
                        if (r.rx_cnt == 4'd0) begin
                            if (maj) begin
                                n.rx_st = RX_IDLE;
                            end else begin
                                n.rx_cnt = 4'd1;
                            end
                        end else if (r.rx_cnt < nbits - 4'd1) begin
                            n.rx_dat = {maj, r.rx_dat[8:1]};
                            n.rx_cnt = r.rx_cnt + 4'd1;
                        end else begin
                            // stop bit middle; a full buffer loses the frame
                            ninth = (r.mode == MODE_UART8) ? maj : r.rx_dat[8];
                            if (!r.ri && (!r.sm2 || ninth)) begin
                                n.rbuf = (r.mode == MODE_UART8) ? r.rx_dat[8:1] : r.rx_dat[7:0];
                                n.rb8  = ninth;
                                set_ri = 1'b1;
                            end
                            n.rx_st = RX_IDLE;
                        end
                    end
                end
            end
            default: begin
                n.rx_st = RX_IDLE;
            end
        endcase

        // ******************************
        // register writes and reads
        // ******************************
        if (wr) begin
            case (paddr)
                ADDR_SER_CTRL: begin
                    n.mode = pwdata[7:6];
                    n.sm2  = pwdata[SC_SM2];
                    n.ren  = pwdata[SC_REN];
                    n.tb8  = pwdata[SC_TB8];
                    n.rb8  = pwdata[SC_RB8];
                    n.ti   = pwdata[SC_TI];
                    n.ri   = pwdata[SC_RI];
                end
                ADDR_SER_BUF: begin
                    // transmit side only; receive buffer untouched
                    n.tx_st  = TX_WAIT;
                    n.tx_cnt = 4'd0;
                    if (shift_md) begin
                        n.tx_sh = {2'b00, 1'b1, pwdata[7:0]};
                    end else begin
                        n.tx_sh = {1'b1, (r.mode == MODE_UART8) | r.tb8, pwdata[7:0], 1'b0};
                    end
                end
                ADDR_PWR_CTRL: begin
                    n.double_rate_bit = pwdata[PW_DOUBLE_RATE_BIT];
                end
                ADDR_T2_CTRL: begin
                    n.t2ovf  = pwdata[T2_OVF];
                    n.t2ext  = pwdata[T2_EXT];
                    n.rxb2   = pwdata[T2_RXB];
                    n.txb2   = pwdata[T2_TXB];
                    n.t2exen = pwdata[T2_EXEN];
                    n.t2run  = pwdata[T2_RUN];
                    n.t2ct   = pwdata[T2_CT];
                    n.t2cprl = pwdata[T2_CPRL];
                end
                ADDR_T2_RELOAD_LO: n.t2rel[7:0]  = pwdata[7:0];
                ADDR_T2_RELOAD_HI: n.t2rel[15:8] = pwdata[7:0];
                ADDR_T2_COUNT_LO:  n.t2cnt[7:0]  = pwdata[7:0];
                ADDR_T2_COUNT_HI:  n.t2cnt[15:8] = pwdata[7:0];
                ADDR_T1_RELOAD:    n.t1rel       = pwdata[7:0];
                default: begin
                end
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        n.ti    = n.ti | set_ti;
        n.ri    = n.ri | set_ri;
        n.t2ovf = n.t2ovf | set_ovf;
        n.t2ext = n.t2ext | set_ext;
        // read data latched in the setup phase, shown in the access phase
        if (psel && !penable) begin
            case (paddr)
                ADDR_SER_CTRL:     n.prd = {24'h00_0000, r.mode, r.sm2, r.ren, r.tb8, r.rb8, r.ti, r.ri};
                ADDR_SER_BUF:      n.prd = {24'h00_0000, r.rbuf};
                ADDR_PWR_CTRL:     n.prd = {24'h00_0000, r.double_rate_bit, 7'h00};
                ADDR_T2_CTRL:      n.prd = {24'h00_0000, r.t2ovf, r.t2ext, r.rxb2, r.txb2,
                                            r.t2exen, r.t2run, r.t2ct, r.t2cprl};
                ADDR_T2_RELOAD_LO: n.prd = {24'h00_0000, r.t2rel[7:0]};
                ADDR_T2_RELOAD_HI: n.prd = {24'h00_0000, r.t2rel[15:8]};
                ADDR_T2_COUNT_LO:  n.prd = {24'h00_0000, r.t2cnt[7:0]};
                ADDR_T2_COUNT_HI:  n.prd = {24'h00_0000, r.t2cnt[15:8]};
                ADDR_T1_RELOAD:    n.prd = {24'h00_0000, r.t1rel};
                default:           n.prd = 32'h0000_0000;
            endcase
        end

        // ******************************
        // pins
        // ******************************
        // shift clock low S3..S5 while a shift-mode transfer runs
        n.sclk = !(shift_md && (n.tx_st == TX_SEND || n.rx_st == RX_SHIFT) &&
                   n.ph >= PH_SCLK_LO0 && n.ph <= PH_SCLK_LO1);
        n.txp  = shift_md ? n.sclk : n.txd;
        n.oe_n = !(shift_md && n.tx_st == TX_SEND);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= ST_RST;
        end else begin
            r <= n;
        end
    end

    // ******************************
    // checks
    // ******************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr_shift;
        wr_buf && shift_md && r.tx_st == TX_IDLE;
    endsequence
    property p_tx_start_delay;
        s_wr_shift |=> (r.tx_st != TX_SEND)[*8] ##[6:17] (r.tx_st == TX_SEND);
    endproperty
    a_tx_start_delay: assert property (p_tx_start_delay)
        else $error("shift-mode send started at wrong time");

    property p_sclk_low;
        (r.tx_st == TX_SEND && shift_md && r.ph == 4'd5) |=> !txd_out;
    endproperty
    a_sclk_low: assert property (p_sclk_low)
        else $error("shift clock not low in S3..S5");

    property p_ti_cause;
        ($rose(r.ti) && !$past(wr_ctl)) |-> $past(r.tx_st) == TX_SEND;
    endproperty
    a_ti_cause: assert property (p_ti_cause)
        else $error("tx flag set without a send");

    property p_flags_sticky;
        ($fell(r.ti) || $fell(r.ri)) |-> $past(wr_ctl);
    endproperty
    a_flags_sticky: assert property (p_flags_sticky)
        else $error("flag cleared by hardware");

    property p_tf2_quiet;
        (baud2 && !r.t2ovf && !wr_t2c) |=> !r.t2ovf;
    endproperty
    a_tf2_quiet: assert property (p_tf2_quiet)
        else $error("overflow flag set in baud mode");

    property p_ext_flag;
        (baud2 && r.t2exen && t2_fall && !wr) |=> r.t2ext && r.t2rel == $past(r.t2rel);
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("external edge mishandled in baud mode");

    property p_mp_filter;
        ($rose(r.ri) && r.mode[1] && r.sm2 && !$past(wr_ctl)) |-> r.rb8;
    endproperty
    a_mp_filter: assert property (p_mp_filter)
        else $error("rx flag set for data frame under filter");

    sequence s_bad_start;
        r.rx_st == RX_ASYNC && rx_x16 && r.rx_div == SMP_C && r.rx_cnt == 4'd0 && maj;
    endsequence
    property p_false_start;
        s_bad_start |=> r.rx_st == RX_IDLE;
    endproperty
    a_false_start: assert property (p_false_start)
        else $error("false start bit not rejected");

endmodule : spfm_top
`default_nettype wire

/* testbench/spfm_peer.sv */
`timescale 1ns/1ns
`default_nettype none
// remote station with 9-bit frames; BIT is the bit time in pclk cycles
module spfm_peer #(parameter int BIT = 32) (
    input  wire logic pclk,
    input  wire logic line_in,
    input  wire logic data_in,
    input  wire logic data_oe_n,
    output logic      line_out
);
    logic [8:0] got;
    logic [7:0] sgot   = 8'h00;
    int         frames = 0;
    int         sbits  = 0;
    // line idles high like a pulled-up pin
    initial begin
        line_out = 1'b1;
    end
    // send start, nine bits lsb first, stop
    task automatic send(input logic [8:0] dat);
        line_out <= 1'b0;
        repeat (BIT) @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            line_out <= dat[i];
            repeat (BIT) @(posedge pclk);
        end
        line_out <= 1'b1;
        repeat (BIT) @(posedge pclk);
    endtask : send
    // receive: sample mid bit; the stop bit is not kept
    always begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge pclk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge pclk);
            got[i] = line_in;
        end
        frames++;
    end
    // shift mode: take the data pin at each rising shift clock while the device drives it
    always @(posedge line_in) begin
        if (!data_oe_n) begin
            sgot = {data_in, sgot[7:1]};
            sbits++;
        end
    end
endmodule : spfm_peer
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import spfm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, txd_out, rxd_out, rxd_oe_n, peer_out, err;
    logic        n9, sm2;
    logic        t2x;
    logic [1:0]  md;
    logic [7:0]  paddr, d, c;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] lfsr = 16'h9677;
    int          fail_count = 0;
    int          checks = 0;
    int          f0;
    wire logic   rxd_line = rxd_oe_n ? peer_out : rxd_out;
    spfm_top u_spfm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd_out(txd_out),
        .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .timer_two_external_input(t2x));
    spfm_peer #(.BIT(32)) u_spfm_peer (.pclk(pclk), .line_in(txd_out), .data_in(rxd_out), .data_oe_n(rxd_oe_n),
        .line_out(peer_out));
    // 125 MHz clock
    always #4 pclk = ~pclk;
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic exp_ri(input logic filt, input logic ninth);
        return !filt || ninth;
    endfunction : exp_ri
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    task automatic final_report;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    // hang guard, about ten times the expected run
    initial begin
        #200000;
        fail_count++;
        final_report();
    end
    // main sequence
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        t2x = 1'b1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_SER_CTRL, 8'h00);
        chk({1'b0, q[7:0]}, 9'h000);
        apb(1'b0, 8'h24, 8'h00);
        chk({err, q[7:0]}, 9'h100);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_SER_CTRL, {m[1:0], 6'h00});
            apb(1'b0, ADDR_SER_CTRL, 8'h00);
            chk({7'h00, q[7:6]}, {7'h00, m[1:0]});
        end
        // double rate: 32 pclk per bit in the fixed 9-bit mode
        apb(1'b1, ADDR_PWR_CTRL, 8'h80);
        // second timer as baud source: full reload gives 32 pclk per bit in mode 3
        apb(1'b1, ADDR_T2_RELOAD_LO, 8'hFF);
        apb(1'b1, ADDR_T2_RELOAD_HI, 8'hFF);
        apb(1'b1, ADDR_T2_COUNT_LO, 8'hFF);
        apb(1'b1, ADDR_T2_COUNT_HI, 8'hFF);
        apb(1'b1, ADDR_T2_CTRL, 8'h3C);
        for (int i = 0; i < 4; i++) begin
            lfsr = step(lfsr);
            d = lfsr[7:0];
            n9 = (i < 2) ? i[0] : lfsr[8];
            sm2 = (i < 2) ? 1'b1 : lfsr[9];
            md = (i < 2) ? MODE_UART9F : 2'b11;
            apb(1'b1, ADDR_SER_CTRL, {md, sm2, 1'b1, n9, 3'b000});
            f0 = u_spfm_peer.frames;
            // both directions at once
            fork
                apb(1'b1, ADDR_SER_BUF, d);
                u_spfm_peer.send({n9, ~d});
            join
            for (int k = 0; k < 2000 && u_spfm_peer.frames == f0; k++) begin
                @(posedge pclk);
            end
            chk({8'h00, u_spfm_peer.frames != f0}, 9'h001);
            repeat (32) @(posedge pclk);
            chk(u_spfm_peer.got, {n9, d});
            apb(1'b0, ADDR_SER_CTRL, 8'h00);
            c = q[7:0];
            chk({7'h00, c[SC_TI], c[SC_RI]}, {7'h00, 1'b1, exp_ri(sm2, n9)});
            apb(1'b0, ADDR_SER_BUF, 8'h00);
            if (exp_ri(sm2, n9)) begin
                chk({c[SC_RB8], q[7:0]}, {n9, ~d});
            end
        end
        // external edge in baud mode only raises its flag; overflow flag stays clear
        t2x <= 1'b0;
        repeat (4) @(posedge pclk);
        t2x <= 1'b1;
        apb(1'b0, ADDR_T2_CTRL, 8'h00);
        chk({1'b0, q[7:0]}, 9'h07C);
        // shift mode send: data on the rx pin, shift clock on the tx pin
        apb(1'b1, ADDR_SER_CTRL, 8'h00);
        lfsr = step(lfsr);
        d = lfsr[7:0];
        apb(1'b1, ADDR_SER_BUF, d);
        repeat (200) @(posedge pclk);
        chk({1'b0, u_spfm_peer.sgot}, {1'b0, d});
        chk(u_spfm_peer.sbits[8:0], 9'd8);
        apb(1'b0, ADDR_SER_CTRL, 8'h00);
        chk({rxd_oe_n, q[7:0]}, 9'h102);
        // shift mode receive of an idle-high pin fills the buffer with ones
        apb(1'b1, ADDR_SER_CTRL, 8'h10);
        repeat (150) @(posedge pclk);
        apb(1'b0, ADDR_SER_CTRL, 8'h00);
        chk({1'b0, q[7:0]}, 9'h011);
        apb(1'b0, ADDR_SER_BUF, 8'h00);
        chk({1'b0, q[7:0]}, 9'h0FF);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
